// ---- src/serial_status_consts.vh ----
// Constants for the serial status flag logic
`ifndef SERIAL_STATUS_CONSTS_VH
`define SERIAL_STATUS_CONSTS_VH
`define ADDR_STATUS 12'h000
`define ADDR_CONTROL 12'h004
`define ADDR_RXDATA 12'h008
`define ADDR_TXDATA 12'h00C
`define STATUS_RESET 8'h84
`define CONTROL_RESET 8'h00
`define BIT_TX_BUFFER_EMPTY_FLAG 7
`define BIT_RX_BUFFER_FULL_FLAG 6
`define BIT_OVERRUN_ERROR_FLAG 5
`define BIT_FER 4
`define BIT_PER 3
`define BIT_TX_END_FLAG 2
`define BIT_MPB 1
`define BIT_TX_MULTIPROC_BIT 0
`define CTL_TX_EN 5
`define CTL_RX_EN 4
`define CTL_SYNC 3
`define CTL_ODD 2
`define CTL_TWO_STOP 1
`define CLEARABLE_MASK 8'hF8
`endif

// ---- src/rx_check.v ----
// Receive character checker: parity and stop bit tests
`timescale 1ns/1ps
module rx_check
(
	input wire [7:0] data,
	input wire parity_bit,
	input wire odd_parity,
	input wire stop_first,
	input wire async_mode,
	output wire parity_bad,
	output wire frame_bad
);
	// Ones count of data plus parity must match the selected sense
	assign parity_bad = async_mode & ((^data ^ parity_bit) != odd_parity);
	// Only the first stop bit is looked at; second is ignored
	assign frame_bad = async_mode & ~stop_first;
endmodule // rx_check

// ---- src/read_tracker.v ----
// Record, for each of flag bits 7 to 3 only, of a 1 having been read since last write
`timescale 1ns/1ps
`include "serial_status_consts.vh"
module read_tracker
(
	input wire clock,
	input wire reset,
	input wire read_strobe,
	input wire write_strobe,
	input wire [7:0] flags,
	output reg [7:0] armed_q
);
	// A write consumes the record; a read of 1 arms it
	always @(posedge clock)
	begin
		if (reset)
			armed_q <= 8'h00;
		else if (write_strobe)
			armed_q <= 8'h00;
		else if (read_strobe)
			armed_q <= armed_q | (flags & `CLEARABLE_MASK);
	end
endmodule // read_tracker

// ---- src/serial_status_flags.v ----
// Status flag register of the serial interface with APB access
`timescale 1ns/1ps
`include "serial_status_consts.vh"
module serial_status_flags
(
	input wire clock,
	input wire reset,
	input wire standby,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire dma_tx_write,
	input wire dma_rx_read,
	input wire tx_load,
	input wire tx_last_bit,
	input wire rx_done,
	input wire [7:0] rx_char,
	input wire rx_parity_bit,
	input wire rx_stop_first,
	input wire rx_mp_bit,
	output reg rx_blocked,
	output reg tx_blocked,
	output reg tx_multiproc_bit,
	output reg tx_enable_bit,
	output reg rx_enable_bit,
	output reg [7:0] rx_data_register
);
	reg tx_buffer_empty_flag_q;
	reg rx_buffer_full_flag_q;
	reg overrun_error_flag_q;
	reg framing_error_flag_q;
	reg parity_error_flag_q;
	reg tx_end_flag_q;
	reg rx_multiproc_bit_q;
	reg tx_multiproc_bit_q;
	reg [7:0] control_q;
	reg [7:0] rxdata_q;
	wire [7:0] status;
	wire [7:0] armed;
	wire access;
	wire wr_status;
	wire rd_status;
	wire [7:0] clr;
	wire parity_bad;
	wire frame_bad;
	wire rx_ok;
	wire rx_stalled;
	wire clean;
	wire tx_clear;
	wire rx_clear;
	wire any_reset;
	wire [7:0] status_init;

	// Reset image of the status byte, sliced for the two transmit flags below
	assign status_init = `STATUS_RESET;
	// Standby behaves exactly like reset for this register
	// reset and standby
	assign any_reset = reset | standby;
	// Taken once, on the first access cycle; the ready cycle repeats nothing
	// no lockout
	assign access = psel & penable & ~pready;
	assign wr_status = access & pwrite & (paddr == `ADDR_STATUS);
	assign rd_status = access & ~pwrite & (paddr == `ADDR_STATUS);

	assign status = {tx_buffer_empty_flag_q, rx_buffer_full_flag_q,
		overrun_error_flag_q, framing_error_flag_q,
		parity_error_flag_q, tx_end_flag_q,
		rx_multiproc_bit_q, tx_multiproc_bit_q};

	read_tracker u_track
	(
		.clock(clock),
		.reset(any_reset),
		.read_strobe(rd_status),
		.write_strobe(wr_status),
		.flags(status),
		.armed_q(armed)
	);

	// Clear only where 0 written and 1 previously read
	// ones ignored
	assign clr = {8{wr_status}} & ~pwdata[7:0] & armed & `CLEARABLE_MASK;

	rx_check u_check
	(
		.data(rx_char),
		.parity_bit(rx_parity_bit),
		.odd_parity(control_q[`CTL_ODD]),
		.stop_first(rx_stop_first),
		.async_mode(~control_q[`CTL_SYNC]),
		.parity_bad(parity_bad),
		.frame_bad(frame_bad)
	);

	assign rx_stalled = overrun_error_flag_q | framing_error_flag_q
		| parity_error_flag_q;
	assign rx_ok = rx_done & control_q[`CTL_RX_EN] & ~rx_stalled;
	// second stop bit never reaches the checker
	assign clean = ~parity_bad & ~frame_bad;
	assign tx_clear = dma_tx_write | clr[`BIT_TX_BUFFER_EMPTY_FLAG];
	assign rx_clear = dma_rx_read | clr[`BIT_RX_BUFFER_FULL_FLAG];

	// Transmit-empty and transmit-end flags
	always @(posedge clock)
	begin
		if (any_reset)
		begin
			tx_buffer_empty_flag_q <= status_init[`BIT_TX_BUFFER_EMPTY_FLAG];
			tx_end_flag_q <= status_init[`BIT_TX_END_FLAG];
		end
		else if (!control_q[`CTL_TX_EN])
		begin
			tx_buffer_empty_flag_q <= 1'b1;
			tx_end_flag_q <= 1'b1;
		end
		// set wins over a same-cycle clear
		else if (tx_load)
			tx_buffer_empty_flag_q <= 1'b1;
		else if (tx_clear)
		begin
			tx_buffer_empty_flag_q <= 1'b0;
			tx_end_flag_q <= 1'b0;
		end
		else if (tx_last_bit && tx_buffer_empty_flag_q)
			tx_end_flag_q <= 1'b1;
	end

	// Receive-full flag and data register
	always @(posedge clock)
	begin
		if (any_reset)
		begin
			rx_buffer_full_flag_q <= 1'b0;
			rxdata_q <= 8'h00;
			rx_multiproc_bit_q <= 1'b0;
		end
		// held on errors and while disabled
		else if (rx_ok && !rx_buffer_full_flag_q)
		begin
			rxdata_q <= rx_char;
			rx_multiproc_bit_q <= rx_mp_bit;
			rx_buffer_full_flag_q <= clean;
		end
		else if (rx_clear)
			rx_buffer_full_flag_q <= 1'b0;
	end

	// Error flags: a set in the clear cycle wins
	always @(posedge clock)
	begin
		if (any_reset)
		begin
			overrun_error_flag_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
			parity_error_flag_q <= 1'b0;
		end
		else
		begin
			if (rx_ok && rx_buffer_full_flag_q)
				overrun_error_flag_q <= 1'b1;
			else if (clr[`BIT_OVERRUN_ERROR_FLAG])
				overrun_error_flag_q <= 1'b0;
			// stop bit 0 sets framing error
			if (rx_ok && !rx_buffer_full_flag_q && frame_bad)
				framing_error_flag_q <= 1'b1;
			else if (clr[`BIT_FER])
				framing_error_flag_q <= 1'b0;
			if (rx_ok && !rx_buffer_full_flag_q && parity_bad)
				parity_error_flag_q <= 1'b1;
			else if (clr[`BIT_PER])
				parity_error_flag_q <= 1'b0;
		end
	end

	// Software written bits: control and multiprocessor transmit bit
	always @(posedge clock)
	begin
		if (any_reset)
		begin
			control_q <= `CONTROL_RESET;
			tx_multiproc_bit_q <= 1'b0;
		end
		else if (wr_status)
			// plain bit; bits 2 and 1 not written
			tx_multiproc_bit_q <= pwdata[`BIT_TX_MULTIPROC_BIT];
		else if (access && pwrite && paddr == `ADDR_CONTROL)
			control_q <= pwdata[7:0];
	end

	// APB answer and registered outputs
	always @(posedge clock)
	begin
		if (any_reset)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			rx_blocked <= 1'b0;
			tx_blocked <= 1'b0;
			tx_multiproc_bit <= 1'b0;
			tx_enable_bit <= 1'b0;
			rx_enable_bit <= 1'b0;
			rx_data_register <= 8'h00;
		end
		else
		begin
			// Ready pulses one cycle into the access phase
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && penable && !pready && !pwrite)
			begin
				if (paddr == `ADDR_STATUS)
					prdata <= {24'h00_0000, status};
				else if (paddr == `ADDR_CONTROL)
					prdata <= {24'h00_0000, control_q};
				else if (paddr == `ADDR_RXDATA)
					prdata <= {24'h00_0000, rxdata_q};
				else
					pslverr <= 1'b1;
			end
			else if (psel && penable && !pready && pwrite
				&& paddr != `ADDR_STATUS && paddr != `ADDR_CONTROL)
				pslverr <= 1'b1;
			rx_blocked <= rx_stalled;
			tx_blocked <= overrun_error_flag_q & control_q[`CTL_SYNC];
			tx_multiproc_bit <= tx_multiproc_bit_q;
			tx_enable_bit <= control_q[`CTL_TX_EN];
			rx_enable_bit <= control_q[`CTL_RX_EN];
			rx_data_register <= rxdata_q;
		end
	end
endmodule // serial_status_flags

// ---- sim/serial_status_chk.sv ----
// Assertion checker for the serial status flag logic
`timescale 1ns/1ps
`include "serial_status_consts.vh"
module serial_status_chk
(
	input wire clock,
	input wire reset,
	input wire standby,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire rx_done,
	input wire rx_blocked,
	input wire tx_enable_bit,
	input wire rx_enable_bit,
	input wire tx_multiproc_bit,
	input wire [7:0] rx_data_register
);
	// Access taken this cycle; standby resets like reset
	wire take = psel && penable && !pready;
	default clocking @(posedge clock); endclocking
	default disable iff (reset || standby);
	a_ready_wait: assert property (take |=> pready)
		else $error("no answer after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_unmapped_err: assert property
		(pready && paddr == `ADDR_TXDATA |-> pslverr)
		else $error("unmapped access not refused");
	a_err_paired: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_upper_zero: assert property
		(pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_txen_copy: assert property
		(take && pwrite && paddr == `ADDR_CONTROL |=> ##1
		tx_enable_bit == $past(pwdata[`CTL_TX_EN], 2))
		else $error("transmit enable not taken");
	a_rxen_copy: assert property
		(take && pwrite && paddr == `ADDR_CONTROL |=> ##1
		rx_enable_bit == $past(pwdata[`CTL_RX_EN], 2))
		else $error("receive enable not taken");
	a_tx_multiproc_bit_copy: assert property
		(take && pwrite && paddr == `ADDR_STATUS |=> ##1
		tx_multiproc_bit == $past(pwdata[`BIT_TX_MULTIPROC_BIT], 2))
		else $error("multiprocessor bit not taken");
	a_rx_hold: assert property
		(rx_done ##1 rx_blocked |=> $stable(rx_data_register))
		else $error("blocked reception stored data");
	a_blk_cause: assert property
		($rose(rx_blocked) |-> $past(rx_done, 2))
		else $error("error flag without reception");
	c_write: cover property (take && pwrite);
	c_blocked: cover property (rx_done ##1 rx_blocked);
	c_refused: cover property (pslverr);
endmodule // serial_status_chk
bind serial_status_flags serial_status_chk u_chk
(
	.clock(clock), .reset(reset), .standby(standby), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_done(rx_done), .rx_blocked(rx_blocked),
	.tx_enable_bit(tx_enable_bit), .rx_enable_bit(rx_enable_bit),
	.tx_multiproc_bit(tx_multiproc_bit),
	.rx_data_register(rx_data_register)
);

// ---- sim/serial_far_end.sv ----
// Far-side model: DMA controller and shifter event source
`timescale 1ns/1ps
module serial_far_end
(
	input wire clock,
	input wire [4:0] ev,
	input wire [9:0] frame,
	output reg dma_tx_write,
	output reg dma_rx_read,
	output reg tx_load,
	output reg tx_last_bit,
	output reg rx_done,
	output wire [7:0] rx_char,
	output wire rx_parity_bit,
	output wire rx_stop_first
);
	reg [9:0] line_q;
	assign {rx_stop_first, rx_parity_bit, rx_char} = line_q;
	// Pulses last one cycle; lines scramble outside them so stale data shows
	always @(posedge clock)
	begin
		{rx_done, tx_last_bit, tx_load, dma_rx_read, dma_tx_write} <= ev;
		line_q <= ev[4] ? frame : ~line_q;
	end
endmodule // serial_far_end

// ---- sim/serial_status_flags_tb_top.sv ----
// Testbench for the serial status flag logic
`timescale 1ns/1ps
`include "serial_status_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h, expected %h", $time, g, e); end end
module serial_status_flags_tb_top;
	reg clock = 0;
	reg reset = 1;
	reg standby = 0;
	reg psel = 0;
	reg penable = 0;
	reg pwrite = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0;
	reg [4:0] ev = 0;
	reg [9:0] frame = 0;
	reg [7:0] c1, c2;
	reg [32:0] e;
	reg [32:0] exp_q[$];
	integer seed = 32'h1096;
	integer miscompares = 0;
	integer checks = 0;
	wire [31:0] prdata;
	wire [7:0] rx_char;
	wire pready, pslverr, dma_tx_write, dma_rx_read, tx_load, tx_last_bit;
	wire rx_done, rx_parity_bit, rx_stop_first;
	serial_status_flags dut (.clock(clock), .reset(reset),
		.standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dma_tx_write(dma_tx_write),
		.dma_rx_read(dma_rx_read), .tx_load(tx_load),
		.tx_last_bit(tx_last_bit), .rx_done(rx_done), .rx_char(rx_char),
		.rx_parity_bit(rx_parity_bit), .rx_stop_first(rx_stop_first),
		.rx_mp_bit(1'b0), .rx_blocked(), .tx_blocked(),
		.tx_multiproc_bit(), .tx_enable_bit(), .rx_enable_bit(),
		.rx_data_register());
	serial_far_end far (.clock(clock), .ev(ev), .frame(frame),
		.dma_tx_write(dma_tx_write), .dma_rx_read(dma_rx_read),
		.tx_load(tx_load), .tx_last_bit(tx_last_bit), .rx_done(rx_done),
		.rx_char(rx_char), .rx_parity_bit(rx_parity_bit),
		.rx_stop_first(rx_stop_first));
	// Free-running clock
	always #4 clock = ~clock;
	task report_and_stop;
	begin
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	// Request held until ready is seen at a rising edge
	task xfer(input [11:0] a, input w, input [7:0] d);
	begin
		@(posedge clock);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		psel <= 0;
		penable <= 0;
	end
	endtask
	task rd(input [11:0] a, input [32:0] x);
	begin
		exp_q.push_back(x);
		xfer(a, 0, 8'h00);
	end
	endtask
	task pulse(input [4:0] x, input [9:0] f);
	begin
		@(posedge clock);
		ev <= x;
		frame <= f;
		@(posedge clock);
		ev <= 0;
	end
	endtask
	// Even parity, one stop bit; either may be spoiled
	task rx(input [7:0] d, input pbad, input sbad);
		pulse(5'h10, {~sbad, (^d) ^ pbad, d});
	endtask
	// Each read answer against the oldest note; errors ignore data
	always @(posedge clock)
	begin
		if (pready && !pwrite)
		begin
			e = exp_q.pop_front();
			`CHK(pslverr ? 33'h1_0000_0000 : {1'b0, prdata}, e)
		end
	end
	initial
	begin
		repeat (2000) @(posedge clock);
		miscompares++;
		report_and_stop;
	end
	initial
	begin
		repeat (6) @(posedge clock);
		reset <= 0;
		rd(`ADDR_STATUS, 8'h84);
		rd(`ADDR_TXDATA, 33'h1_0000_0000);
		xfer(`ADDR_STATUS, 1, 8'hFF);
		rd(`ADDR_STATUS, 8'h85);
		xfer(`ADDR_CONTROL, 1, 8'h30);
		xfer(`ADDR_STATUS, 1, 8'h7F);
		rd(`ADDR_STATUS, 8'h01);
		c1 = $random(seed);
		rx(c1, 0, 0);
		xfer(`ADDR_STATUS, 1, 8'h01);
		rd(`ADDR_STATUS, 8'h41);
		rd(`ADDR_RXDATA, c1);
		c2 = $random(seed);
		rx(c2, 0, 0);
		rd(`ADDR_STATUS, 8'h61);
		rd(`ADDR_RXDATA, c1);
		pulse(5'h02, 10'h000);
		rd(`ADDR_STATUS, 8'h21);
		xfer(`ADDR_STATUS, 1, 8'h01);
		rd(`ADDR_STATUS, 8'h01);
		pulse(5'h04, 10'h000);
		rd(`ADDR_STATUS, 8'h81);
		pulse(5'h08, 10'h000);
		rd(`ADDR_STATUS, 8'h85);
		pulse(5'h01, 10'h000);
		rd(`ADDR_STATUS, 8'h01);
		c1 = $random(seed);
		rx(c1, 0, 1);
		rd(`ADDR_STATUS, 8'h11);
		rx(c2, 0, 0);
		rd(`ADDR_RXDATA, c1);
		xfer(`ADDR_STATUS, 1, 8'h01);
		c1 = $random(seed);
		rx(c1, 1, 0);
		rd(`ADDR_STATUS, 8'h09);
		rd(`ADDR_RXDATA, c1);
		xfer(`ADDR_CONTROL, 1, 8'h20);
		rd(`ADDR_STATUS, 8'h09);
		@(posedge clock);
		standby <= 1;
		@(posedge clock);
		standby <= 0;
		rd(`ADDR_STATUS, 8'h84);
		repeat (2) @(posedge clock);
		report_and_stop;
	end
endmodule // serial_status_flags_tb_top
